/* src/mds_pkg.sv */
package mds_pkg;

   // Register selects on the core access port.
   localparam int MDS_NUM_BYTES = 6;
   localparam logic [2:0] MDS_SEL_BYTE0 = 3'h0;
   localparam logic [2:0] MDS_SEL_BYTE1 = 3'h1;
   localparam logic [2:0] MDS_SEL_BYTE2 = 3'h2;
   localparam logic [2:0] MDS_SEL_BYTE3 = 3'h3;
   localparam logic [2:0] MDS_SEL_BYTE4 = 3'h4;
   localparam logic [2:0] MDS_SEL_BYTE5 = 3'h5;
   localparam logic [2:0] MDS_SEL_CTRL = 3'h6;

   // Shift control register layout.
   localparam int MDS_CTRL_ERR_BIT = 7;
   localparam int MDS_CTRL_OVF_BIT = 6;
   localparam int MDS_CTRL_DIR_BIT = 5;
   localparam int MDS_CTRL_CNT_LSB = 0;
   localparam int MDS_CTRL_CNT_W = 5;
   localparam logic [7:0] MDS_CTRL_RESET = 8'h00;
   localparam logic [7:0] MDS_BYTE_RESET = 8'h00;

   // Timing: one machine cycle per core_clk period.
   localparam int MDS_CLK_PERIOD_NS = 50;
   localparam int MDS_TCY_NS = 50;
   localparam int MDS_LONG_TCY = 6;
   localparam int MDS_SHORT_TCY = 4;
   localparam logic [2:0] MDS_LONG_CYCLES = 3'(MDS_LONG_TCY * MDS_TCY_NS / MDS_CLK_PERIOD_NS);
   localparam logic [2:0] MDS_SHORT_CYCLES = 3'(MDS_SHORT_TCY * MDS_TCY_NS / MDS_CLK_PERIOD_NS);
   localparam int MDS_SHIFTS_PER_CYCLE = 6;
   localparam logic [5:0] MDS_LONG_DIV_STEPS = 6'h20;
   localparam logic [5:0] MDS_SHORT_DIV_STEPS = 6'h10;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [2:0] sel;
      logic [7:0] data;
   } mds_req_t;

   typedef enum logic [3:0] {
      SEQ_IDLE = 4'h0,
      SEQ_W0 = 4'h1,
      SEQ_W01 = 4'h2,
      SEQ_W012 = 4'h3,
      SEQ_W0123 = 4'h4,
      SEQ_W01234 = 4'h5,
      SEQ_W014 = 4'h6,
      SEQ_W04 = 4'h7,
      SEQ_W041 = 4'h8
   } mds_seq_t;

   typedef enum logic [2:0] {
      OP_IDLE = 3'h0,
      OP_LONG_DIV = 3'h1,
      OP_SHORT_DIV = 3'h2,
      OP_MUL = 3'h3,
      OP_SHIFT = 3'h4,
      OP_NORM = 3'h5
   } mds_op_t;

   // Number of bit steps to take this cycle, capped at the per-cycle limit.
   function automatic logic [2:0] mds_cap(input logic [5:0] n);
      return (n > 6'(MDS_SHIFTS_PER_CYCLE)) ? 3'(MDS_SHIFTS_PER_CYCLE) : n[2:0];
   endfunction

endpackage

/* src/mds_div_step.sv */
`timescale 1ns/1ps
`default_nettype none
module mds_div_step
   import mds_pkg::*;
#(
   parameter int STEPS = MDS_SHIFTS_PER_CYCLE
)
(
   input wire logic [15:0] rem_in,
   input wire logic [31:0] quo_in,
   input wire logic [15:0] divisor,
   input wire logic [2:0] n_steps,
   output logic [15:0] rem_out,
   output logic [31:0] quo_out
);

   // Restoring division; dividend bits leave the top of quo as quotient bits enter the bottom.
   always_comb begin
      logic [16:0] r;
      logic [31:0] q;
      r = {1'b0, rem_in};
      q = quo_in;
      for (int i = 0; i < STEPS; i++) begin
         if (3'(i) < n_steps) begin
            r = {r[15:0], q[31]};
            q = {q[30:0], 1'b0};
            if (r >= {1'b0, divisor}) begin
               r = r - {1'b0, divisor};
               q[0] = 1'b1;
            end
         end
      end
      rem_out = r[15:0];
      quo_out = q;
   end

endmodule // mds_div_step
`default_nettype wire

/* src/mds_shift_step.sv */
`timescale 1ns/1ps
`default_nettype none
module mds_shift_step
   import mds_pkg::*;
(
   input wire logic [31:0] val,
   input wire logic [4:0] count,
   input wire logic dir_right,
   input wire logic normalize,
   output logic [31:0] val_next,
   output logic [4:0] count_next,
   output logic [2:0] amt
);

   function automatic logic [2:0] lead_zeros(input logic [31:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < MDS_SHIFTS_PER_CYCLE; i++) begin
         if (n == 3'(i) && !v[31 - i]) begin
            n = n + 3'h1;
         end
      end
      return n;
   endfunction

   // A zero operand cannot be normalised, so it is left alone.
   wire [2:0] norm_amt = (val == 32'h0000_0000) ? 3'h0 : lead_zeros(val);
   assign amt = normalize ? norm_amt : mds_cap({1'b0, count});
   assign val_next = (dir_right && !normalize) ? (val >> amt) : (val << amt);
   assign count_next = normalize ? count : (count - {2'b00, amt});

endmodule // mds_shift_step
`default_nettype wire

/* src/mds_unit.sv */
// What this block does
// (RULE_01) Offers 32/16 and 16/16 divide, 16x16 multiply, 32-bit normalize and shift.
// (RULE_02) All operands and results are unsigned integers.
// (RULE_03) Six byte operand/result registers plus one shift control register.
// (RULE_04) Core writes operands, or control for shifts, in the fixed order.
// (RULE_05) The order of operand writes selects the operation; no opcode field.
// (RULE_06) Shift or normalize starts only on the final control register write.
// (RULE_07) Shifter moves the operand up to six bits per machine cycle.
// (RULE_08) Long divide: dividend to bytes 0..3, divisor to 4,5; byte 5 starts.
// (RULE_09) Short divide: dividend to bytes 0,1, divisor to 4,5; byte 5 starts.
// (RULE_10) Multiply: write bytes 0,4,1,5; the byte 5 write starts it.
// (RULE_11) Quotient to bytes 0..3 (or 0,1), remainder to bytes 4,5.
// (RULE_12) Product returns in bytes 0..3, least significant byte in byte 0.
// (RULE_13) Shift operand loaded into bytes 0..3, result read back from them.
// (RULE_14) Low byte carries least significant bits, high byte most significant.
// (RULE_15) Long divide and shifts finish in six cycles, others in four.
// (RULE_16) Core waits for completion before reading results in order.
`timescale 1ns/1ps
`default_nettype none
module mds_unit
   import mds_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire mds_req_t core_req,
   output logic [7:0] rd_data,
   output logic busy,
   output logic done
);

   logic [7:0] arith_byte [MDS_NUM_BYTES];
   logic [7:0] arith_shift_control;
   mds_seq_t seq;
   mds_seq_t next_seq;
   mds_op_t op;
   mds_op_t next_op;
   logic [2:0] cyc_left;
   logic [2:0] next_cyc_left;
   logic [5:0] steps_left;
   logic [31:0] work;
   logic [15:0] rem;
   logic [15:0] divisor;
   logic [4:0] shift_left;
   logic [4:0] norm_cnt;

   wire is_busy = (op != OP_IDLE);
   wire wr_ok = core_req.wr && !is_busy;
   wire wr_blocked = core_req.wr && is_busy;
   wire sel_byte = (core_req.sel < 3'(MDS_NUM_BYTES));
   wire sel_ctrl = (core_req.sel == MDS_SEL_CTRL);
   // Last busy cycle: results land on the edge that closes it, and done follows in the next cycle.
   wire finish = is_busy && (cyc_left == 3'h1);

   // The operation is inferred purely from the history of accepted writes.
   wire start_long = wr_ok && seq == SEQ_W01234 && core_req.sel == MDS_SEL_BYTE5;   // [RULE_05] [RULE_08]
   wire start_short = wr_ok && seq == SEQ_W014 && core_req.sel == MDS_SEL_BYTE5;    // [RULE_05] [RULE_09]
   wire start_mul = wr_ok && seq == SEQ_W041 && core_req.sel == MDS_SEL_BYTE5;      // [RULE_05] [RULE_10]
   wire start_shift = wr_ok && seq == SEQ_W0123 && sel_ctrl;                         // [RULE_06] [RULE_13]
   wire start_div = start_long || start_short;

   // Operand assembly, low byte in the least significant bits.
   wire [31:0] op32 = {arith_byte[3], arith_byte[2], arith_byte[1], arith_byte[0]};  // [RULE_14]
   wire [15:0] op16 = {arith_byte[1], arith_byte[0]};                                // [RULE_14]
   wire [15:0] second16 = {core_req.data, arith_byte[4]};                            // [RULE_14]
   wire [31:0] product = 32'(op16) * 32'(second16);                                  // [RULE_01] [RULE_02]
   wire [4:0] new_cnt = core_req.data[MDS_CTRL_CNT_LSB +: MDS_CTRL_CNT_W];
   wire new_dir = core_req.data[MDS_CTRL_DIR_BIT];
   wire cur_dir = arith_shift_control[MDS_CTRL_DIR_BIT];

   // A zero count written to the control register asks for a normalize.
   wire start_norm = start_shift && (new_cnt == 5'h00);

   // Refused writes leave the history alone, so a stray byte during a run cannot forge a sequence.
   always_comb begin
      next_seq = SEQ_IDLE;
      if (!wr_ok) begin
         next_seq = seq;
      end else if (core_req.sel == MDS_SEL_BYTE0) begin
         next_seq = SEQ_W0;                                                       // [RULE_04]
      end else begin
         unique case (seq)
            SEQ_IDLE: next_seq = SEQ_IDLE;
            SEQ_W0: begin
               if (core_req.sel == MDS_SEL_BYTE1) begin
                  next_seq = SEQ_W01;
               end else if (core_req.sel == MDS_SEL_BYTE4) begin
                  next_seq = SEQ_W04;
               end
            end
            SEQ_W01: begin
               if (core_req.sel == MDS_SEL_BYTE2) begin
                  next_seq = SEQ_W012;
               end else if (core_req.sel == MDS_SEL_BYTE4) begin
                  next_seq = SEQ_W014;
               end
            end
            SEQ_W012: next_seq = (core_req.sel == MDS_SEL_BYTE3) ? SEQ_W0123 : SEQ_IDLE;
            SEQ_W0123: next_seq = (core_req.sel == MDS_SEL_BYTE4) ? SEQ_W01234 : SEQ_IDLE;
            SEQ_W01234: next_seq = SEQ_IDLE;
            SEQ_W014: next_seq = SEQ_IDLE;
            SEQ_W04: next_seq = (core_req.sel == MDS_SEL_BYTE1) ? SEQ_W041 : SEQ_IDLE;
            SEQ_W041: next_seq = SEQ_IDLE;
            default: next_seq = SEQ_IDLE;
         endcase
      end
   end

   always_comb begin
      next_op = op;
      next_cyc_left = cyc_left;
      if (start_long) begin
         next_op = OP_LONG_DIV;
         next_cyc_left = MDS_LONG_CYCLES;                                        // [RULE_15]
      end else if (start_short) begin
         next_op = OP_SHORT_DIV;
         next_cyc_left = MDS_SHORT_CYCLES;                                       // [RULE_15]
      end else if (start_mul) begin
         next_op = OP_MUL;
         next_cyc_left = MDS_SHORT_CYCLES;                                       // [RULE_15]
      end else if (start_shift) begin
         next_op = start_norm ? OP_NORM : OP_SHIFT;
         next_cyc_left = MDS_LONG_CYCLES;                                        // [RULE_15]
      end else if (finish) begin
         next_op = OP_IDLE;
         next_cyc_left = 3'h0;
      end else if (is_busy) begin
         next_cyc_left = cyc_left - 3'h1;
      end
   end

   logic [15:0] div_rem;
   logic [31:0] div_quo;
   logic [31:0] sh_val;
   logic [4:0] sh_left;
   logic [2:0] sh_amt;
   wire [2:0] div_steps = mds_cap(steps_left);
   wire is_div = (op == OP_LONG_DIV) || (op == OP_SHORT_DIV);
   wire is_shift = (op == OP_SHIFT) || (op == OP_NORM);

   // Six quotient steps a cycle: 32 steps need all six cycles, 16 steps only three of the four.
   mds_div_step #(
      .STEPS(MDS_SHIFTS_PER_CYCLE)
   ) u_div (
      .rem_in(rem),
      .quo_in(work),
      .divisor(divisor),
      .n_steps(is_div ? div_steps : 3'h0),
      .rem_out(div_rem),
      .quo_out(div_quo)
   );

   mds_shift_step u_shift (
      .val(work),
      .count(shift_left),
      .dir_right(cur_dir),
      .normalize(op == OP_NORM),
      .val_next(sh_val),
      .count_next(sh_left),
      .amt(sh_amt)                                                               // [RULE_07]
   );

   wire [4:0] norm_total = norm_cnt + {2'b00, sh_amt};
   // A zero divisor is not trapped: the datapath runs on and returns all ones as quotient.
   // Only the overflow flag tells the core that such a result is meaningless.
   wire div_zero = (divisor == 16'h0000);
   wire mul_ovf = (work[31:16] != 16'h0000);

   // Result bytes placed at completion, low byte first.
   wire [31:0] res_low = is_div ? div_quo : (is_shift ? sh_val : work);         // [RULE_11] [RULE_12] [RULE_13]
   wire wr_low_half = finish;
   wire wr_high_half = finish && (op != OP_SHORT_DIV);                           // [RULE_11]
   wire wr_rem = finish && is_div;                                               // [RULE_11]

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         seq <= SEQ_IDLE;
         op <= OP_IDLE;
         cyc_left <= 3'h0;
      end else begin
         seq <= next_seq;
         op <= next_op;
         cyc_left <= next_cyc_left;
      end
   end

   // Working registers for the iterative datapath.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         work <= 32'h0000_0000;
         rem <= 16'h0000;
         divisor <= 16'h0000;
         steps_left <= 6'h00;
         shift_left <= 5'h00;
         norm_cnt <= 5'h00;
      end else if (start_div) begin
         work <= start_long ? op32 : {op16, 16'h0000};                          // [RULE_08] [RULE_09]
         rem <= 16'h0000;
         divisor <= second16;
         steps_left <= start_long ? MDS_LONG_DIV_STEPS : MDS_SHORT_DIV_STEPS;
      end else if (start_mul) begin
         work <= product;                                                        // [RULE_10]
      end else if (start_shift) begin
         work <= op32;                                                           // [RULE_13]
         shift_left <= new_cnt;
         norm_cnt <= 5'h00;
      end else if (is_div) begin
         work <= div_quo;
         rem <= div_rem;
         steps_left <= steps_left - {3'h0, div_steps};
      end else if (is_shift) begin
         work <= sh_val;                                                         // [RULE_07]
         shift_left <= sh_left;
         norm_cnt <= norm_total;
      end
   end

   // One write enable per operand byte, decoded once for the register array below.
   logic [MDS_NUM_BYTES-1:0] byte_wr;
   always_comb begin
      for (int i = 0; i < MDS_NUM_BYTES; i++) begin
         byte_wr[i] = wr_ok && sel_byte && (core_req.sel == 3'(i));
      end
   end

   // Operand/result byte registers.
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int i = 0; i < MDS_NUM_BYTES; i++) begin
            arith_byte[i] <= MDS_BYTE_RESET;
         end
      end else begin
         for (int i = 0; i < MDS_NUM_BYTES; i++) begin
            if (byte_wr[i]) begin
               arith_byte[i] <= core_req.data;                                   // [RULE_03]
            end
         end
         if (wr_low_half) begin
            arith_byte[0] <= res_low[7:0];                                       // [RULE_12] [RULE_14]
            arith_byte[1] <= res_low[15:8];
         end
         if (wr_high_half && !wr_rem) begin
            arith_byte[2] <= res_low[23:16];
            arith_byte[3] <= res_low[31:24];
         end
         if (wr_rem) begin
            if (op == OP_LONG_DIV) begin
               arith_byte[2] <= res_low[23:16];
               arith_byte[3] <= res_low[31:24];
            end
            arith_byte[4] <= div_rem[7:0];                                       // [RULE_11]
            arith_byte[5] <= div_rem[15:8];
         end
      end
   end

   // Control register. An error raised in the same cycle as a clearing read stays set.
   wire rd_ctrl = core_req.rd && sel_ctrl;
   wire ovf_now = finish && ((is_div && div_zero) || ((op == OP_MUL) && mul_ovf));

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         arith_shift_control <= MDS_CTRL_RESET;
      end else begin
         if (wr_ok && sel_ctrl) begin
            arith_shift_control[MDS_CTRL_DIR_BIT] <= new_dir;
            arith_shift_control[MDS_CTRL_CNT_LSB +: MDS_CTRL_CNT_W] <= new_cnt;
         end
         // Normalize reports its total shift distance in the count field when it ends.
         if (finish && op == OP_NORM) begin
            arith_shift_control[MDS_CTRL_CNT_LSB +: MDS_CTRL_CNT_W] <= norm_total;
         end
         if (start_div || start_mul || start_shift) begin
            arith_shift_control[MDS_CTRL_OVF_BIT] <= 1'b0;
         end else if (ovf_now) begin
            arith_shift_control[MDS_CTRL_OVF_BIT] <= 1'b1;
         end
         if (wr_blocked) begin
            arith_shift_control[MDS_CTRL_ERR_BIT] <= 1'b1;
         end else if (rd_ctrl) begin
            arith_shift_control[MDS_CTRL_ERR_BIT] <= 1'b0;
         end
      end
   end

   // Reads answer one cycle later; results are stale until busy falls.
   wire [2:0] rd_idx = sel_byte ? core_req.sel : MDS_SEL_BYTE0;
   wire [7:0] rd_mux = sel_byte ? arith_byte[rd_idx] : (sel_ctrl ? arith_shift_control : 8'h00);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= 8'h00;
         done <= 1'b0;
      end else begin
         if (core_req.rd) begin
            rd_data <= rd_mux;                                                   // [RULE_16]
         end
         done <= finish;
      end
   end

   assign busy = is_busy;

endmodule // mds_unit
`default_nettype wire

/* tb/mds_unit_props.sv */
`timescale 1ns/1ps
`default_nettype none
module mds_unit_props
   import mds_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire mds_req_t core_req,
   input wire logic [7:0] rd_data,
   input wire logic busy,
   input wire logic done
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // Writes taken while busy are refused, so they never enter the history.
   logic [14:0] hist;
   wire logic wr_idle = core_req.wr && !busy;
   wire logic sel5 = wr_idle && core_req.sel == MDS_SEL_BYTE5;
   wire logic long_go = sel5 && hist == {MDS_SEL_BYTE0, MDS_SEL_BYTE1, MDS_SEL_BYTE2, MDS_SEL_BYTE3, MDS_SEL_BYTE4};
   wire logic short_go = sel5 && hist[8:0] == {MDS_SEL_BYTE0, MDS_SEL_BYTE1, MDS_SEL_BYTE4};
   wire logic mul_go = sel5 && hist[8:0] == {MDS_SEL_BYTE0, MDS_SEL_BYTE4, MDS_SEL_BYTE1};
   wire logic shift_go = wr_idle && core_req.sel == MDS_SEL_CTRL
      && hist[11:0] == {MDS_SEL_BYTE0, MDS_SEL_BYTE1, MDS_SEL_BYTE2, MDS_SEL_BYTE3};

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hist <= 15'h7FFF;
      end else if (wr_idle) begin
         hist <= {hist[11:0], core_req.sel};
      end
   end

   long_div_time_a: assert property (
      long_go |=> busy [*6] ##1 (done && !busy))
      else $error("long divide did not finish after six busy cycles");
   short_op_time_a: assert property (
      (short_go || mul_go) |=> busy [*4] ##1 (done && !busy))
      else $error("short divide or multiply did not finish after four busy cycles");
   shift_time_a: assert property (
      shift_go |=> busy [*6] ##1 (done && !busy))
      else $error("shift did not finish after six busy cycles");
   start_cause_a: assert property (
      $rose(busy) |-> $past(long_go || short_go || mul_go || shift_go))
      else $error("operation started without a complete write sequence");
   done_pulse_a: assert property (
      done |-> (!busy && $past(busy)) ##1 !done)
      else $error("done is not a single pulse after busy");
   busy_span_a: assert property (
      $rose(busy) |-> busy [*4] ##[1:3] !busy)
      else $error("busy length outside four to six cycles");
   unmapped_read_a: assert property (
      (core_req.rd && core_req.sel == 3'h7) |=> rd_data == 8'h00)
      else $error("unmapped select read nonzero");
   read_hold_a: assert property (
      !core_req.rd |=> $stable(rd_data))
      else $error("read data changed without a read");
endmodule // mds_unit_props

bind mds_unit mds_unit_props props_i (.core_clk(core_clk), .rst_n(rst_n), .core_req(core_req),
   .rd_data(rd_data), .busy(busy), .done(done));
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import mds_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   mds_req_t core_req = '0;
   logic [7:0] rd_data;
   logic busy;
   logic done;
   int mismatches = 0;
   int n_compared = 0;

   always #25 core_clk = ~core_clk;

   mds_unit uut (.core_clk(core_clk), .rst_n(rst_n), .core_req(core_req), .rd_data(rd_data), .busy(busy),
      .done(done));

   task automatic tally_and_finish();
      if (mismatches == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Inputs move 2 ns after the edge so the design never samples them mid-change.
   task automatic step();
      @(posedge core_clk);
      #2;
   endtask

   // The write strobe stays up between back-to-back writes; idle() lowers it, as rd() does after each read.
   task automatic wr(input logic [2:0] sel, input logic [7:0] d);
      core_req = '{wr: 1'b1, rd: 1'b0, sel: sel, data: d};
      step();
   endtask

   task automatic idle();
      core_req = '0;
      step();
   endtask

   task automatic rd(input logic [2:0] sel, output logic [7:0] d);
      core_req = '{wr: 1'b0, rd: 1'b1, sel: sel, data: 8'h00};
      step();
      idle();
      d = rd_data;
   endtask

   task automatic rd_bytes(input int base, input int n, output logic [31:0] v);
      logic [7:0] b;
      v = '0;
      for (int k = 0; k < n; k++) begin
         rd(3'(base + k), b);
         v[8*k +: 8] = b;
      end
   endtask

   task automatic wait_done(input int exp);
      int n;
      n = 1;
      chk("busy", 1'b1, busy);
      while (done !== 1'b1 && n < 20) begin
         step();
         n++;
      end
      chk("done cycle", exp, n);
      if (n >= 20) tally_and_finish();
   endtask

   task automatic run_long(input logic [31:0] a, input logic [15:0] b);
      logic [31:0] v;
      logic [7:0] c;
      for (int k = 0; k < 4; k++) wr(3'(k), a[8*k +: 8]);
      wr(MDS_SEL_BYTE4, b[7:0]);
      wr(MDS_SEL_BYTE5, b[15:8]);
      idle();
      wait_done(6);
      rd_bytes(0, 4, v);
      chk("long quotient", (b == 0) ? 32'hFFFF_FFFF : a / b, v);
      if (b != 0) begin
         rd_bytes(4, 2, v);
         chk("long remainder", a % b, v);
      end
      rd(MDS_SEL_CTRL, c);
      chk("divide overflow", b == 0, c[MDS_CTRL_OVF_BIT]);
   endtask

   task automatic run_short(input logic [15:0] a, input logic [15:0] b);
      logic [31:0] v;
      wr(MDS_SEL_BYTE2, 8'hA5);
      wr(MDS_SEL_BYTE3, 8'h5A);
      wr(MDS_SEL_BYTE0, a[7:0]);
      wr(MDS_SEL_BYTE1, a[15:8]);
      wr(MDS_SEL_BYTE4, b[7:0]);
      wr(MDS_SEL_BYTE5, b[15:8]);
      idle();
      wait_done(4);
      rd_bytes(0, 4, v);
      chk("short quotient", {16'h5AA5, 16'(a / b)}, v);
      rd_bytes(4, 2, v);
      chk("short remainder", 32'(a % b), v);
   endtask

   task automatic run_mul(input logic [15:0] a, input logic [15:0] b);
      logic [31:0] v;
      logic [7:0] c;
      wr(MDS_SEL_BYTE0, a[7:0]);
      wr(MDS_SEL_BYTE4, b[7:0]);
      wr(MDS_SEL_BYTE1, a[15:8]);
      wr(MDS_SEL_BYTE5, b[15:8]);
      idle();
      wait_done(4);
      rd_bytes(0, 4, v);
      chk("product", 32'(a) * 32'(b), v);
      rd(MDS_SEL_CTRL, c);
      chk("product overflow", 32'(a) * 32'(b) > 32'h0000_FFFF, c[MDS_CTRL_OVF_BIT]);
   endtask

   task automatic run_shift(input logic [31:0] a, input logic [7:0] c);
      logic [31:0] v;
      logic [31:0] exp;
      logic [4:0] cnt;
      logic [7:0] r;
      exp = c[MDS_CTRL_DIR_BIT] ? a >> c[4:0] : a << c[4:0];
      cnt = c[4:0];
      // A zero count means normalize, which reports how far it moved.
      if (c[4:0] == 5'h00) begin
         exp = a;
         while (exp != 0 && exp[31] == 1'b0) begin
            exp = exp << 1;
            cnt++;
         end
      end
      for (int k = 0; k < 4; k++) wr(3'(k), a[8*k +: 8]);
      wr(MDS_SEL_CTRL, c);
      idle();
      wait_done(6);
      rd_bytes(0, 4, v);
      chk("shift result", exp, v);
      rd(MDS_SEL_CTRL, r);
      chk("shift control", {2'b00, c[5], cnt}, r);
   endtask

   task automatic run_refused();
      logic [31:0] v;
      logic [7:0] c;
      for (int k = 0; k < 4; k++) wr(3'(k), 8'(k * 3 + 1));
      wr(MDS_SEL_BYTE4, 8'h07);
      wr(MDS_SEL_BYTE5, 8'h00);
      wr(MDS_SEL_BYTE0, 8'hFF);
      idle();
      wait_done(5);
      rd_bytes(0, 4, v);
      chk("quotient after refused write", 32'h0A07_0401 / 32'd7, v);
      rd(MDS_SEL_CTRL, c);
      chk("error flag set", 1'b1, c[MDS_CTRL_ERR_BIT]);
      rd(MDS_SEL_CTRL, c);
      chk("error flag cleared", 1'b0, c[MDS_CTRL_ERR_BIT]);
   endtask

   task automatic run_broken();
      logic [7:0] b;
      wr(MDS_SEL_BYTE0, 8'h01);
      wr(MDS_SEL_BYTE1, 8'h02);
      wr(MDS_SEL_BYTE5, 8'h03);
      idle();
      chk("busy after broken order", 1'b0, busy);
      wr(3'h7, 8'hFF);
      rd(3'h7, b);
      chk("unmapped read", 8'h00, b);
      rd(MDS_SEL_BYTE5, b);
      chk("stored byte", 8'h03, b);
   endtask

   initial begin
      logic [7:0] b;
      repeat (12) @(posedge core_clk);
      #2;
      rst_n = 1'b1;
      step();
      for (int k = 0; k < 8; k++) begin
         rd(3'(k), b);
         chk("reset value", (k == 6) ? MDS_CTRL_RESET : MDS_BYTE_RESET, b);
      end
      run_long(32'hDEAD_BEEF, 16'h1234);
      run_long(32'hFFFF_FFFF, 16'hFFFF);
      run_long(32'h1234_5678, 16'h0000);
      run_short(16'hFFFE, 16'h0007);
      run_mul(16'hFFFF, 16'hFFFF);
      run_mul(16'h00FF, 16'h0101);
      run_shift(32'h8123_4567, 8'h05);
      run_shift(32'h8000_0001, 8'h3F);
      run_shift(32'h0001_2345, 8'h00);
      run_refused();
      run_broken();
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
